// [design/dbcs_bank_track.sv]
/*
  Per-bank command legality and state tracker of the memory side.
  Decodes each registered command, moves each bank through its states,
  flags commands that are illegal for the addressed bank.
  Assumes the command pins come from outside and are synchronised here.
  Assumes every timing window of the map header is a least time, so the
  tracker rounds each one up to whole ref_clk cycles.
  An illegal command changes no bank or device state and freezes every
  running window for that cycle; a real part's answer is undefined, and
  holding still keeps the tracker repeatable.
  Burst interrupts are not judged here: the controller keeps those rules,
  and a read or write to an active bank is always taken; in write recovery only a write is.
*/
`timescale 1ns/1ns
`default_nettype none
`include "dbcs_map.svh"

module dbcs_bank_track #(
  parameter int NBANK = 8
) (
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire dbcs_pkg::dbcs_pins_t pins,
  output var  logic [NBANK-1:0]    bank_open,
  output var  logic [NBANK-1:0]    bank_busy,
  output var  logic                all_idle,
  output var  logic                illegal_cmd,
  output var  logic                cmd_accepted
);
  import dbcs_pkg::*;

  //--------------------------------------------------------------------
  // Timing counts
  //--------------------------------------------------------------------
  // Every window is held in ref_clk cycles, rounded up so that a bank is
  // never released early; the cost is up to one spare cycle per window.
  // Write recovery is added to the burst, since recovery only starts once
  // the last data beat has gone in.
  // The counters are eight bits wide, which covers the longest window.
  localparam logic [`DBCS_CNT_W-1:0] TRP_C  = `DBCS_CNT_W'(`DBCS_CYC(`DBCS_TRP_PS));
  localparam logic [`DBCS_CNT_W-1:0] TRCD_C = `DBCS_CNT_W'(`DBCS_CYC(`DBCS_TRCD_PS));
  localparam logic [`DBCS_CNT_W-1:0] TWR_C  = `DBCS_CNT_W'(`DBCS_CYC(`DBCS_TWR_PS));
  localparam logic [`DBCS_CNT_W-1:0] TRFC_C = `DBCS_CNT_W'(`DBCS_CYC(`DBCS_TRFC_PS));
  localparam logic [`DBCS_CNT_W-1:0] TMRD_C = `DBCS_CNT_W'(`DBCS_TMRD_CYC);
  localparam logic [`DBCS_CNT_W-1:0] BURST_C = `DBCS_CNT_W'(`DBCS_BURST_CYC);

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------
  // Everything the tracker remembers sits in one record: the two pin
  // stages, per-bank state and timer, the device-wide state and timer,
  // and the registered copies of every output.
  typedef struct packed {
    dbcs_pins_t                          p1;
    dbcs_pins_t                          p2;
    dbcs_bank_st_t [NBANK-1:0]           st;
    logic [NBANK-1:0][`DBCS_CNT_W-1:0]   cnt;
    dbcs_dev_st_t                        dev;
    logic [`DBCS_CNT_W-1:0]              dcnt;
    logic [NBANK-1:0]                    open;
    logic [NBANK-1:0]                    busy;
    logic                                idle;
    logic                                ill;
    logic                                acc;
  } dbcs_state_t;

  dbcs_state_t      state_ff;
  dbcs_state_t      nxt_state;
  dbcs_cmd_t        cmd;
  logic [2:0]       cba;
  logic             c_a10;
  logic [NBANK-1:0] sel_bank; // One-hot bank address of the command
  logic [NBANK-1:0] hit_bank; // Banks that a banked command lands on

  //--------------------------------------------------------------------
  // Command decode
  //--------------------------------------------------------------------
  // Chip-select high wins over every other line. The one strobe pattern
  // that no command uses (write enable alone) decodes as no operation,
  // so it can neither move a bank nor raise a refusal.
  always_comb begin
    cba   = state_ff.p2.ba;
    c_a10 = state_ff.p2.addr[`DBCS_A10_BIT];
    if (state_ff.p2.cs_n) begin
      cmd = DBCS_CMD_NOP;
    end else begin
      case ({state_ff.p2.ras_n, state_ff.p2.cas_n, state_ff.p2.we_n})
        3'h7:    cmd = DBCS_CMD_NOP;
        3'h5:    cmd = DBCS_CMD_READ;
        3'h4:    cmd = DBCS_CMD_WRITE;
        3'h3:    cmd = DBCS_CMD_ACT;
        3'h2:    cmd = DBCS_CMD_PRE;
        3'h1:    cmd = DBCS_CMD_REF;
        3'h0:    cmd = DBCS_CMD_MRS;
        default: cmd = DBCS_CMD_NOP;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // Bank addressing
  //--------------------------------------------------------------------
  // One compare per bank. Precharge with the all-banks bit widens the hit
  // to every bank; other commands ignore that bit here, since for reads
  // and writes it selects auto-precharge instead.
  for (genvar g = 0; g < NBANK; g++) begin : g_bank_hit
    assign sel_bank[g] = (cba == 3'(g));
    assign hit_bank[g] = sel_bank[g] || ((cmd == DBCS_CMD_PRE) && c_a10);
  end

  //--------------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------------
  // An illegal command leaves all bank and device state untouched; the response of a real
  // part is undefined, so holding still keeps the model predictable.
  always_comb begin
    logic any_ill;
    logic all_i;
    logic hit;
    any_ill = 1'b0;
    all_i   = (state_ff.dev == DBCS_DEV_NORMAL);
    hit     = 1'b0;
    // Start from the current record and shift the pin stages; every
    // branch below only changes what the command or a timer moves
    nxt_state = state_ff;
    nxt_state.p1 = pins;
    nxt_state.p2 = state_ff.p1;
    // Refresh and mode set look at the banks as they stand before this
    // edge, so a bank closing in this very cycle still counts as busy
    for (int b = 0; b < NBANK; b++) begin
      if (state_ff.st[b] != DBCS_IDLE) all_i = 1'b0;
    end

    // Device-wide busy periods block every command but nop. No bank can
    // leave idle meanwhile, so the bank case is skipped.
    if (state_ff.dev != DBCS_DEV_NORMAL) begin
      if (cmd != DBCS_CMD_NOP) any_ill = 1'b1;
    end else begin
      for (int b = 0; b < NBANK; b++) begin
        // Only the addressed bank judges a banked command
        hit = hit_bank[b];
        case (state_ff.st[b])
          // Idle: a column command finds no open row; activate starts the
          // row timer, and a precharge here is legal and changes nothing
          DBCS_IDLE: begin
            if (hit && (cmd == DBCS_CMD_READ || cmd == DBCS_CMD_WRITE)) any_ill = 1'b1;
            if ((3'(b) == cba) && cmd == DBCS_CMD_ACT) begin
              nxt_state.st[b]  = DBCS_ACTIVATING;
              nxt_state.cnt[b] = TRCD_C;
            end
          end
          // Open row: column commands start bursts, auto-precharge picks the
          // closing path; a second activate would clobber the open row
          DBCS_ACTIVE: begin
            if ((3'(b) == cba) && cmd == DBCS_CMD_ACT) any_ill = 1'b1;
            if (hit && cmd == DBCS_CMD_PRE) begin
              nxt_state.st[b]  = DBCS_PRECHARGING;
              nxt_state.cnt[b] = TRP_C;
            end else if ((3'(b) == cba) && cmd == DBCS_CMD_READ) begin
              nxt_state.st[b]  = c_a10 ? DBCS_READ_AP : DBCS_ACTIVE;
              nxt_state.cnt[b] = BURST_C;
            end else if ((3'(b) == cba) && cmd == DBCS_CMD_WRITE) begin
              nxt_state.st[b]  = c_a10 ? DBCS_WRITE_AP : DBCS_WREC;
              nxt_state.cnt[b] = BURST_C + TWR_C;
            end
          end
          // Auto-precharge burst: the bank stays locked until the burst and
          // the close that follows it have run
          DBCS_READ_AP, DBCS_WRITE_AP: begin
            if (hit && cmd != DBCS_CMD_NOP) any_ill = 1'b1;
            else if (state_ff.cnt[b] <= `DBCS_CNT_W'(1)) begin
              nxt_state.st[b]  = (state_ff.st[b] == DBCS_READ_AP) ? DBCS_PRECHARGING : DBCS_WREC_AP;
              nxt_state.cnt[b] = (state_ff.st[b] == DBCS_READ_AP) ? TRP_C : TWR_C;
            end else begin
              nxt_state.cnt[b] = state_ff.cnt[b] - `DBCS_CNT_W'(1);
            end
          end
          // Precharging: a repeated precharge is a no operation and does not
          // restart the window, so a controller may repeat it safely
          DBCS_PRECHARGING: begin
            if (hit && cmd != DBCS_CMD_NOP && cmd != DBCS_CMD_PRE) any_ill = 1'b1;
            else if (state_ff.cnt[b] <= `DBCS_CNT_W'(1)) nxt_state.st[b] = DBCS_IDLE;
            else nxt_state.cnt[b] = state_ff.cnt[b] - `DBCS_CNT_W'(1);
          end
          // Row activating: nothing but deselect or no operation until the
          // row is open
          DBCS_ACTIVATING: begin
            if (hit && cmd != DBCS_CMD_NOP) any_ill = 1'b1;
            else if (state_ff.cnt[b] <= `DBCS_CNT_W'(1)) nxt_state.st[b] = DBCS_ACTIVE;
            else nxt_state.cnt[b] = state_ff.cnt[b] - `DBCS_CNT_W'(1);
          end
          // Write recovery: a new write restarts the burst and its recovery;
          // anything else to the bank has to wait for recovery to end
          DBCS_WREC: begin
            if ((3'(b) == cba) && cmd == DBCS_CMD_WRITE) begin
              nxt_state.st[b]  = c_a10 ? DBCS_WRITE_AP : DBCS_WREC;
              nxt_state.cnt[b] = BURST_C + TWR_C;
            end else if (hit && cmd != DBCS_CMD_NOP) any_ill = 1'b1;
            else if (state_ff.cnt[b] <= `DBCS_CNT_W'(1)) nxt_state.st[b] = DBCS_ACTIVE;
            else nxt_state.cnt[b] = state_ff.cnt[b] - `DBCS_CNT_W'(1);
          end
          // Write recovery before auto-precharge: the bank closes by itself
          // and takes no command at all until its precharge window starts
          DBCS_WREC_AP: begin
            if (hit && cmd != DBCS_CMD_NOP) any_ill = 1'b1;
            else if (state_ff.cnt[b] <= `DBCS_CNT_W'(1)) begin
              nxt_state.st[b]  = DBCS_PRECHARGING;
              nxt_state.cnt[b] = TRP_C;
            end else nxt_state.cnt[b] = state_ff.cnt[b] - `DBCS_CNT_W'(1);
          end
          // Unknown state value (all eight codes are named): fall back to idle rather than lock the bank
          // for good
          default: nxt_state.st[b] = DBCS_IDLE;
        endcase
      end
      // Refresh and mode set need every bank idle; self-refresh entry rides
      // on the same command, so it is covered as well
      if (cmd == DBCS_CMD_REF || cmd == DBCS_CMD_MRS) begin
        if (!all_i) any_ill = 1'b1;
      end
    end

    // Device-wide counters: refresh and mode access occupy the whole part,
    // so one counter serves them both
    case (state_ff.dev)
      // Only a legal refresh or mode set starts a device window
      DBCS_DEV_NORMAL: begin
        if (!any_ill && cmd == DBCS_CMD_REF) begin
          nxt_state.dev  = DBCS_DEV_REFRESH;
          nxt_state.dcnt = TRFC_C;
        end else if (!any_ill && cmd == DBCS_CMD_MRS) begin
          nxt_state.dev  = DBCS_DEV_MRS;
          nxt_state.dcnt = TMRD_C;
        end
      end
      // Both windows end the same way: back to normal when the count is out
      DBCS_DEV_REFRESH, DBCS_DEV_MRS: begin
        if (state_ff.dcnt <= `DBCS_CNT_W'(1)) nxt_state.dev = DBCS_DEV_NORMAL;
        else nxt_state.dcnt = state_ff.dcnt - `DBCS_CNT_W'(1);
      end
      default: nxt_state.dev = DBCS_DEV_NORMAL;
    endcase

    // Illegal command: keep bank and device state as they were; the pulse
    // flags still update below, so the far side sees the refusal
    if (any_ill) begin
      nxt_state.st   = state_ff.st;
      nxt_state.cnt  = state_ff.cnt;
      nxt_state.dev  = state_ff.dev;
      nxt_state.dcnt = state_ff.dcnt;
    end
    // One-cycle pulses: exactly one of them for every command but a no-op
    nxt_state.ill = any_ill;
    nxt_state.acc = !any_ill && (cmd != DBCS_CMD_NOP);
    // Open and busy are exclusive; write recovery counts as open because
    // the row still takes a new write
    for (int b = 0; b < NBANK; b++) begin
      nxt_state.open[b] = (nxt_state.st[b] == DBCS_ACTIVE) || (nxt_state.st[b] == DBCS_WREC);
      nxt_state.busy[b] = (nxt_state.st[b] != DBCS_IDLE) && !nxt_state.open[b];
    end
    nxt_state.idle = (nxt_state.dev == DBCS_DEV_NORMAL) && (nxt_state.st == '0);
  end

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  // Pins arrive from outside, so p1/p2 form the two-stage synchroniser.
  // Reset loads both stages with deselect, so no stale command is decoded
  // in the first two cycles after release.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff      <= '0;
      state_ff.p1   <= '1;
      state_ff.p2   <= '1;
      state_ff.idle <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  // Straight from the state register, so the far side sees no decode glitch
  assign bank_open    = state_ff.open;
  assign bank_busy    = state_ff.busy;
  assign all_idle     = state_ff.idle;
  assign illegal_cmd  = state_ff.ill;
  assign cmd_accepted = state_ff.acc;
endmodule // dbcs_bank_track
`default_nettype wire

// [design/dbcs_map.svh]
/*
  Constants for the per-bank command state tracker: field
  positions of the command pins, timing counts in ref_clk cycles.
  Assumes a 250 MHz ref_clk (4 ns period); times are in picoseconds.
*/
`ifndef DBCS_MAP_SVH
`define DBCS_MAP_SVH

`define DBCS_CLK_PS        4000
// Timing figures in picoseconds, mode set and burst in cycles (plain defaults, adjustable)
`define DBCS_TRP_PS        15000
`define DBCS_TRCD_PS       15000
`define DBCS_TWR_PS        15000
`define DBCS_TRFC_PS       127500
`define DBCS_TMRD_CYC      2
`define DBCS_BURST_CYC     4
// Least times round up to whole cycles
`define DBCS_CYC(ps)       (((ps) + `DBCS_CLK_PS - 1) / `DBCS_CLK_PS)
`define DBCS_A10_BIT       10
`define DBCS_CNT_W         8

`endif

// [design/dbcs_pkg.sv]
/*
  Types for the per-bank command state tracker.
  Assumes dbcs_map.svh sits on the include path.
*/
`default_nettype none
package dbcs_pkg;
  // Decoded command on the pins
  typedef enum logic [2:0] {
    DBCS_CMD_NOP, DBCS_CMD_READ, DBCS_CMD_WRITE, DBCS_CMD_ACT,
    DBCS_CMD_PRE, DBCS_CMD_REF, DBCS_CMD_MRS
  } dbcs_cmd_t;

  // Per-bank state
  typedef enum logic [2:0] {
    DBCS_IDLE, DBCS_ACTIVATING, DBCS_ACTIVE, DBCS_READ_AP, DBCS_WRITE_AP,
    DBCS_WREC, DBCS_WREC_AP, DBCS_PRECHARGING
  } dbcs_bank_st_t;

  // Device-wide state
  typedef enum logic [1:0] {
    DBCS_DEV_NORMAL, DBCS_DEV_REFRESH, DBCS_DEV_MRS
  } dbcs_dev_st_t;

  // Command pins as sampled
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] addr;
  } dbcs_pins_t;
endpackage : dbcs_pkg
`default_nettype wire

// [testbench/dbcs_ctl_model.sv]
/*
  Behavioural memory controller driving the command pins.
  Assumes the caller spaces commands; one command per call.
*/
`timescale 1ns/1ns
`default_nettype none
module dbcs_ctl_model (
  input  wire logic                 ref_clk,
  output var  dbcs_pkg::dbcs_pins_t pins
);
  import dbcs_pkg::*;
  // Deselect with the other lines in a command pattern, so chip-select alone must mask them
  initial pins = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h7, 14'h3fff};
  // One command for one cycle, then deselect with inverted lines; no burst interrupts
  task automatic issue(input dbcs_cmd_t c, input logic [2:0] b, input logic a10);
    logic [2:0] r;
    case (c)
      DBCS_CMD_READ:  r = 3'h5;
      DBCS_CMD_WRITE: r = 3'h4;
      DBCS_CMD_ACT:   r = 3'h3;
      DBCS_CMD_PRE:   r = 3'h2;
      DBCS_CMD_REF:   r = 3'h1;
      DBCS_CMD_MRS:   r = 3'h0;
      default:        r = 3'h7;
    endcase
    @(posedge ref_clk);
    pins <= '{1'b0, r[2], r[1], r[0], b, {3'h0, a10, 10'h155}};
    @(posedge ref_clk);
    pins <= '{1'b1, ~r[2], ~r[1], ~r[0], ~b, 14'h3fff};
  endtask
endmodule // dbcs_ctl_model
`default_nettype wire

// [testbench/dbcs_monitor.sv]
/*
  Port checker for the bank command tracker.
  Assumes it is bound onto dbcs_bank_track and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module dbcs_monitor #(
  parameter int NBANK = 8
) (
  input wire logic                 ref_clk,
  input wire logic                 srst,
  input wire dbcs_pkg::dbcs_pins_t pins,
  input wire logic [NBANK-1:0]     bank_open,
  input wire logic [NBANK-1:0]     bank_busy,
  input wire logic                 all_idle,
  input wire logic                 illegal_cmd,
  input wire logic                 cmd_accepted
);
  import dbcs_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reset_clear_a: assert property (disable iff (1'b0) srst |=> !bank_open && !bank_busy && all_idle
    && !illegal_cmd && !cmd_accepted) else $error("outputs not cleared by reset");
  pulse_excl_a: assert property (!(illegal_cmd && cmd_accepted)) else $error("both pulses at once");
  // Deselect or NOP three edges back must give no pulse
  nop_quiet_a: assert property (($past(pins.cs_n, 3) || ($past(pins.ras_n, 3) && $past(pins.cas_n, 3)
    && $past(pins.we_n, 3))) |-> !illegal_cmd && !cmd_accepted) else $error("pulse after deselect");
  idle_clean_a: assert property (all_idle |-> bank_open == '0 && bank_busy == '0)
    else $error("idle with a bank in use");
  open_busy_a: assert property ((bank_open & bank_busy) == '0) else $error("bank open and busy");
  // The row of bank 0 only opens by way of the activating period
  open_cause_a: assert property ($rose(bank_open[0]) |-> $past(bank_busy[0]))
    else $error("row opened without activating");
  busy_bound_a: assert property ($rose(bank_busy[0]) |-> ##[1:20] !bank_busy[0])
    else $error("bank busy too long");
  dev_bound_a: assert property ((!all_idle && bank_open == '0 && bank_busy == '0) |-> ##[1:40] all_idle)
    else $error("refresh or mode access too long");
endmodule // dbcs_monitor

bind dbcs_bank_track dbcs_monitor #(.NBANK(NBANK)) mon_u (.ref_clk(ref_clk), .srst(srst), .pins(pins),
  .bank_open(bank_open), .bank_busy(bank_busy), .all_idle(all_idle), .illegal_cmd(illegal_cmd),
  .cmd_accepted(cmd_accepted));
`default_nettype wire

// [testbench/ddr2_bank_command_state_rules_tb.sv]
/*
  Self-checking bench for the bank command tracker.
  Assumes the controller model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module ddr2_bank_command_state_rules_tb;
  import dbcs_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst    = 1'b1;
  dbcs_pins_t pins;
  logic [7:0] bank_open, bank_busy;
  logic       all_idle, illegal_cmd, cmd_accepted;
  int         n_mismatch = 0, samples_checked = 0, cyc = 0, n_acc = 0, n_ill = 0;
  initial forever #2 ref_clk = ~ref_clk;
  dbcs_ctl_model ctl_u (.ref_clk(ref_clk), .pins(pins));
  dbcs_bank_track #(.NBANK(8)) dut_u (.ref_clk(ref_clk), .srst(srst), .pins(pins), .bank_open(bank_open),
    .bank_busy(bank_busy), .all_idle(all_idle), .illegal_cmd(illegal_cmd), .cmd_accepted(cmd_accepted));
  // Pulses are tallied every cycle, so back-to-back commands need no exact timing
  always @(posedge ref_clk) begin
    if (cmd_accepted === 1'b1) n_acc++;
    if (illegal_cmd === 1'b1) n_ill++;
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Settle, compare tallies (negative accepted count skips its compare), clear them
  task automatic tally(input int acc, input int ill);
    repeat (8) @(posedge ref_clk);
    #1;
    if (acc >= 0) check("accepted", 8'(n_acc), 8'(acc));
    check("illegal", 8'(n_ill), 8'(ill));
    n_acc = 0;
    n_ill = 0;
  endtask
  task automatic state(input logic [7:0] op, input logic [7:0] bz, input logic idl);
    #1;
    check("open", bank_open, op);
    check("busy", bank_busy, bz);
    check("idle", {7'h0, all_idle}, {7'h0, idl});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_act();
    ctl_u.issue(DBCS_CMD_ACT, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_READ, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_ACT, 3'h1, 1'b0);
    tally(2, 1);
    repeat (10) @(posedge ref_clk);
    state(8'h03, 8'h00, 1'b0);
    $display("test act done");
  endtask
  task automatic t_wrec();
    ctl_u.issue(DBCS_CMD_WRITE, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_READ, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_WRITE, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_ACT, 3'h0, 1'b0);
    tally(2, 2);
    repeat (20) @(posedge ref_clk);
    state(8'h03, 8'h00, 1'b0);
    $display("test wrec done");
  endtask
  task automatic t_ap();
    ctl_u.issue(DBCS_CMD_WRITE, 3'h0, 1'b1);
    ctl_u.issue(DBCS_CMD_PRE, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_READ, 3'h1, 1'b1);
    tally(2, 1);
    state(8'h00, 8'h03, 1'b0);
    repeat (30) @(posedge ref_clk);
    state(8'h00, 8'h00, 1'b1);
    $display("test ap done");
  endtask
  task automatic t_pre();
    ctl_u.issue(DBCS_CMD_ACT, 3'h2, 1'b0);
    repeat (10) @(posedge ref_clk);
    ctl_u.issue(DBCS_CMD_PRE, 3'h2, 1'b0);
    ctl_u.issue(DBCS_CMD_PRE, 3'h2, 1'b0);
    tally(3, 0);
    repeat (10) @(posedge ref_clk);
    state(8'h00, 8'h00, 1'b1);
    $display("test pre done");
  endtask
  task automatic t_dev();
    ctl_u.issue(DBCS_CMD_ACT, 3'h3, 1'b0);
    ctl_u.issue(DBCS_CMD_REF, 3'h0, 1'b0);
    tally(1, 1);
    ctl_u.issue(DBCS_CMD_PRE, 3'h5, 1'b1);
    repeat (10) @(posedge ref_clk);
    state(8'h00, 8'h00, 1'b1);
    ctl_u.issue(DBCS_CMD_REF, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_ACT, 3'h0, 1'b0);
    tally(2, 1);
    state(8'h00, 8'h00, 1'b0);
    repeat (40) @(posedge ref_clk);
    state(8'h00, 8'h00, 1'b1);
    ctl_u.issue(DBCS_CMD_MRS, 3'h0, 1'b0);
    ctl_u.issue(DBCS_CMD_PRE, 3'h0, 1'b0);
    tally(1, 1);
    state(8'h00, 8'h00, 1'b1);
    $display("test dev done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    t_act();
    t_wrec();
    t_ap();
    t_pre();
    t_dev();
    close_out();
  end
endmodule // ddr2_bank_command_state_rules_tb
`default_nettype wire
